// [dv/sfl_host.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------------------
// Host controller model driving the serial flash link
// ------------------------------------------------------------------------------
module sfl_host (
  // Clock
  input  wire logic clk_in,
  // Serial pins
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in
);
  // Half period of the 400 ns link clock in system cycles
  localparam int HALF = 4;

  // Full-cycle transfers when set by the bench
  logic full_cyc = 1'b0;

  // Select high and clock low from time zero, so reset is released deselected
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b1;
  end

  // Waits n system clocks and steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  // Parks the clock at its idle level, then lowers select
  task automatic open_frame(input logic m3);
    sck_out = m3;
    tick(HALF);
    cs_n_out = 1'b0;
    tick(HALF);
  endtask : open_frame

  // Shifts nb bits MSB first; full-cycle mode moves si on the rise, reads so at the fall
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'hff;
    for (int i = 7; i > 7 - nb; i--) begin
      sck_out = 1'b0;
      if (!full_cyc || i == 7) si_out = tx[i];
      tick(HALF);
      if (!full_cyc) rx[i] = so_in;
      sck_out = 1'b1;
      if (full_cyc && i > 0) si_out = tx[i-1];
      tick(HALF);
      if (full_cyc) rx[i] = so_in;
    end
  endtask : xfer

  // Returns the clock low in mode 0, raises select and lets si drift
  task automatic close_frame(input logic m3);
    if (!m3) begin
      sck_out = 1'b0;
      tick(HALF);
    end
    cs_n_out = 1'b1;
    si_out   = ~si_out;
    tick(2 * HALF);
  endtask : close_frame

  // Short select low pulse that wakes the device from ultra-deep power-down
  task automatic wake_pulse();
    cs_n_out = 1'b0;
    tick(HALF);
    cs_n_out = 1'b1;
    tick(2 * HALF);
  endtask : wake_pulse

endmodule : sfl_host

// [dv/test_serial_flash_link_timing.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------------------
// Testbench for the serial flash link
// ------------------------------------------------------------------------------
module test_serial_flash_link_timing;
  localparam int EP_T = 200;
  localparam int P_T  = 100;
  logic        clk_in      = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic        wp_n_in     = 1'b1;
  logic        tx_valid_in = 1'b0;
  logic [7:0]  tx_data_in  = 8'h00;
  wire logic   sck, cs_n, si, so_out, so_oe_out, tx_ready_out, rx_valid_out;
  wire logic   busy_out, pwr_down_out, ultra_pd_out, protect_out;
  wire logic [7:0] rx_data_out;
  int          bad_count = 0;
  int          tests_run = 0;
  int          seed      = 3380;
  logic [7:0]  txq[$];
  logic [7:0]  rxq[$];

  // Clock
  always #25 clk_in = ~clk_in;

  sfl_link #(.EP_CYCLES(EP_T), .P_CYCLES(P_T)) sfl_link_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .so_out(so_out), .so_oe_out(so_oe_out), .wp_n_in(wp_n_in), .tx_data_in(tx_data_in),
    .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out), .rx_data_out(rx_data_out),
    .rx_valid_out(rx_valid_out), .busy_out(busy_out), .pwr_down_out(pwr_down_out),
    .ultra_pd_out(ultra_pd_out), .protect_out(protect_out));

  sfl_host sfl_host_i (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .so_in(so_out));

  // Records every received byte
  always @(posedge clk_in) if (rx_valid_out === 1'b1) rxq.push_back(rx_data_out);

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // Next byte the device should send: FIFO head, or the idle byte when empty
  function automatic logic [7:0] pop_tx();
    if (txq.size() == 0) return sfl_pkg::IDLE_BYTE;
    return txq.pop_front();
  endfunction : pop_tx

  function automatic logic flag(input int s);
    case (s)
      0: return busy_out;
      1: return pwr_down_out;
      2: return ultra_pd_out;
      default: return protect_out;
    endcase
  endfunction : flag

  // Bounded wait for a status flag; a spent bound ends the run
  task automatic wait_for(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (flag(s) !== v && n <= lim) begin
      tick(1);
      n++;
    end
    if (n > lim) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, flag(s), v);
      conclude();
    end
  endtask : wait_for

  // Offers one byte to the FIFO; ok tells whether it was taken
  task automatic push(input logic [7:0] d, output logic ok);
    tx_data_in  = d;
    tx_valid_in = 1'b1;
    ok          = tx_ready_out;
    tick(1);
    if (ok) txq.push_back(d);
  endtask : push

  // Frame of n bytes with random data after a neutral opcode
  task automatic frame(input logic m3, input int n);
    logic [7:0] d, r;
    logic [7:0] sent[$];
    rxq.delete();
    sfl_host_i.open_frame(m3);
    chk1(so_oe_out, 1'b1);
    for (int k = 0; k < n; k++) begin
      d = (k == 0) ? 8'h0b : 8'($random(seed));
      sent.push_back(d);
      sfl_host_i.xfer(d, 8, r);
      if (k > 0) chk8(r, pop_tx());
    end
    sfl_host_i.close_frame(m3);
    if (!m3) void'(pop_tx());
    tick(4);
    chk8(8'(rxq.size()), 8'(n));
    foreach (sent[i]) chk8(rxq[i], sent[i]);
  endtask : frame

  // One-byte command frame in mode 0
  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    sfl_host_i.open_frame(1'b0);
    sfl_host_i.xfer(op, 8, r);
    sfl_host_i.close_frame(1'b0);
    void'(pop_tx());
  endtask : cmd

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    automatic logic [7:0] ops[4] = '{8'h53, 8'h60, 8'h82, 8'h88};
    automatic int         lims[4] = '{sfl_pkg::XFR_CYC, sfl_pkg::COMP_CYC, EP_T, P_T};
    logic       ok;
    logic [7:0] r;
    int         n;
    tick(20);
    sys_rst_in = 1'b0;
    tick(4);
    chk1(tx_ready_out, 1'b1);
    chk1(busy_out, 1'b0);
    push(8'($random(seed)), ok);
    tx_valid_in = 1'b0;
    frame(1'b0, 3);
    $display("test mode0 done");
    push(8'($random(seed)), ok);
    push(8'($random(seed)), ok);
    tx_valid_in = 1'b0;
    sfl_host_i.full_cyc = 1'b1;
    frame(1'b1, 3);
    sfl_host_i.full_cyc = 1'b0;
    $display("test mode3 done");
    n = 0;
    ok = 1'b1;
    while (ok && n < 12) begin
      push(8'($random(seed)), ok);
      n += ok;
    end
    tx_valid_in = 1'b0;
    chk8(8'(n), 8'(sfl_pkg::FIFO_D));
    frame(1'b0, 9);
    chk1(tx_ready_out, 1'b1);
    $display("test fifo done");
    rxq.delete();
    sfl_host_i.xfer(8'hb9, 8, r);
    sfl_host_i.open_frame(1'b0);
    sfl_host_i.xfer(8'hb9, 4, r);
    sfl_host_i.close_frame(1'b0);
    tick(80);
    chk8(8'(rxq.size()), 8'h00);
    chk1(pwr_down_out, 1'b0);
    $display("test abort done");
    cmd(sfl_pkg::OP_DPD);
    wait_for(1, 1'b1, sfl_pkg::EDPD_CYC, n);
    chk1(busy_out, 1'b1);
    cmd(sfl_pkg::OP_RESUME);
    wait_for(0, 1'b0, sfl_pkg::RDPD_CYC, n);
    chk1(pwr_down_out, 1'b0);
    $display("test deep done");
    cmd(sfl_pkg::OP_UDPD);
    wait_for(2, 1'b1, sfl_pkg::EUDPD_CYC, n);
    sfl_host_i.wake_pulse();
    wait_for(0, 1'b0, sfl_pkg::XUDPD_CYC, n);
    chk1(ultra_pd_out, 1'b0);
    $display("test ultra done");
    for (int i = 0; i < 4; i++) begin
      cmd(ops[i]);
      chk1(busy_out, 1'b1);
      if (i < 2) cmd(sfl_pkg::OP_DPD);
      wait_for(0, 1'b0, lims[i], n);
      chk1(pwr_down_out, 1'b0);
    end
    $display("test array done");
    wp_n_in = 1'b0;
    wait_for(3, 1'b1, sfl_pkg::WP_CYC, n);
    cmd(sfl_pkg::OP_PROG);
    tick(10);
    chk1(busy_out, 1'b0);
    wp_n_in = 1'b1;
    wait_for(3, 1'b0, sfl_pkg::WP_CYC, n);
    $display("test protect done");
    conclude();
  end

endmodule : test_serial_flash_link_timing

// [verilog/sfl_link.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------------------
// Transmit FIFO
// ------------------------------------------------------------------------------
module sfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // Empty flag and head word; ready is a flop so the top output stays registered
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;
  assign count_next    = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      in_ready_out <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg    <= count_next;
      in_ready_out <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule : sfl_fifo

// ------------------------------------------------------------------------------
// Serial flash link, device end
// ------------------------------------------------------------------------------
module sfl_link #(
  parameter int unsigned EP_CYCLES = sfl_pkg::EP_CYC,
  parameter int unsigned P_CYCLES  = sfl_pkg::P_CYC
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // Serial pins
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  output logic            so_out,
  output logic            so_oe_out,
  input  wire logic       wp_n_in,
  // Transmit data from the core
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  // Received bytes to the core
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  // Status
  output logic            busy_out,
  output logic            pwr_down_out,
  output logic            ultra_pd_out,
  output logic            protect_out
);
  localparam int EDPD_N  = sfl_pkg::EDPD_CYC;
  localparam int EUDPD_N = sfl_pkg::EUDPD_CYC;
  localparam int WP_N    = sfl_pkg::WP_CYC;

  logic [3:0]          meta_reg;
  logic [3:0]          sync_reg;
  logic                sck_prev_reg;
  logic                si_prev_reg;
  logic                cs_prev_reg;
  logic                sck_s, cs_n_s, si_s, wp_n_s;
  logic                sck_rise, sck_fall, cs_rise, spi_on;
  logic [2:0]          bit_cnt_reg;
  logic [1:0]          byte_cnt_reg;
  logic [7:0]          sh_in_reg;
  logic [7:0]          tx_sh_reg;
  logic [7:0]          opcode_reg;
  logic                load_evt;
  logic                fifo_valid;
  logic [7:0]          fifo_data;
  sfl_pkg::sfl_state_e st_reg, st_next;
  logic [sfl_pkg::CNT_W-1:0] cnt_reg, cnt_next;

  // ----------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------------
  // Two flops on every pin
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= 4'hf;
      sync_reg <= 4'hf;
    end else begin
      meta_reg <= {wp_n_in, si_in, cs_n_in, sck_in};
      sync_reg <= meta_reg;
    end
  end

  assign sck_s  = sync_reg[0];
  assign cs_n_s = sync_reg[1];
  assign si_s   = sync_reg[2];
  assign wp_n_s = sync_reg[3];

  // Previous levels for edges, reset to the synchroniser's reset level so no
  // false edge follows reset; si is kept one cycle so the level held before a
  // clock rise is taken even when the host moves si on that same rise
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sck_prev_reg <= 1'b1;
      si_prev_reg  <= 1'b1;
      cs_prev_reg  <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      si_prev_reg  <= si_s;
      cs_prev_reg  <= cs_n_s;
    end
  end

  // Edges are taken fresh, so either clock idle level works at select fall
  assign sck_rise = sck_s && !sck_prev_reg;
  assign sck_fall = !sck_s && sck_prev_reg;
  assign cs_rise  = cs_n_s && !cs_prev_reg;
  assign spi_on   = !cs_n_s && (st_reg != sfl_pkg::SFL_UDPD) && (st_reg != sfl_pkg::SFL_EUDPD);

  // ----------------------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------------------
  // Sample on rise, MSB first; select high clears a partial byte
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !spi_on) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 2'h0;
      sh_in_reg    <= 8'h00;
    end else if (sck_rise) begin
      sh_in_reg   <= {sh_in_reg[6:0], si_prev_reg};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7 && byte_cnt_reg != 2'h3) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
      end
    end
  end

  // Completed byte goes out as a one-cycle strobe; first byte is the opcode
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_data_out  <= 8'h00;
      rx_valid_out <= 1'b0;
      opcode_reg   <= 8'h00;
    end else begin
      rx_valid_out <= 1'b0;
      if (spi_on && sck_rise && bit_cnt_reg == 3'h7) begin
        rx_data_out  <= {sh_in_reg[6:0], si_prev_reg};
        rx_valid_out <= 1'b1;
        if (byte_cnt_reg == 2'h0) opcode_reg <= {sh_in_reg[6:0], si_prev_reg};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------------------
  assign load_evt = spi_on && sck_fall && bit_cnt_reg == 3'h0 && byte_cnt_reg != 2'h0;

  sfl_fifo #(
    .WIDTH (sfl_pkg::DATA_W),
    .DEPTH (sfl_pkg::FIFO_D)
  ) u_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .in_data_in    (tx_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (load_evt),
    .out_data_out  (fifo_data)
  );

  // Launch on fall, inside the low phase; empty FIFO sends idle bytes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      so_out    <= 1'b1;
      so_oe_out <= 1'b0;
      tx_sh_reg <= 8'h00;
    end else if (!spi_on) begin
      so_oe_out <= 1'b0;
    end else begin
      so_oe_out <= 1'b1;
      if (load_evt) begin
        so_out    <= fifo_valid ? fifo_data[7] : sfl_pkg::IDLE_BYTE[7];
        tx_sh_reg <= fifo_valid ? {fifo_data[6:0], 1'b0} : {sfl_pkg::IDLE_BYTE[6:0], 1'b0};
      end else if (sck_fall) begin
        so_out    <= tx_sh_reg[7];
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------------------
  // Countdown start; the pin latency is taken off so the limit holds from the pin
  function automatic logic [sfl_pkg::CNT_W-1:0] load_cnt(input int unsigned n);
    return sfl_pkg::CNT_W'(n - sfl_pkg::PIN_LAT);
  endfunction : load_cnt

  // Next state and countdown; commands act when select rises
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      sfl_pkg::SFL_IDLE: begin
        if (cs_rise && byte_cnt_reg != 2'h0) begin
          case (opcode_reg)
            sfl_pkg::OP_DPD: begin
              st_next  = sfl_pkg::SFL_EDPD;
              cnt_next = load_cnt(sfl_pkg::EDPD_CYC);
            end
            sfl_pkg::OP_UDPD: begin
              st_next  = sfl_pkg::SFL_EUDPD;
              cnt_next = load_cnt(sfl_pkg::EUDPD_CYC);
            end
            sfl_pkg::OP_XFER, sfl_pkg::OP_COMP: begin
              st_next  = sfl_pkg::SFL_BUSY;
              cnt_next = load_cnt(sfl_pkg::XFR_CYC);
            end
            sfl_pkg::OP_EPROG: begin
              if (!protect_out) begin
                st_next  = sfl_pkg::SFL_BUSY;
                cnt_next = load_cnt(EP_CYCLES);
              end
            end
            sfl_pkg::OP_PROG: begin
              if (!protect_out) begin
                st_next  = sfl_pkg::SFL_BUSY;
                cnt_next = load_cnt(P_CYCLES);
              end
            end
            default: ;
          endcase
        end
      end
      sfl_pkg::SFL_BUSY, sfl_pkg::SFL_EDPD, sfl_pkg::SFL_EUDPD, sfl_pkg::SFL_WAKE: begin
        // Array commands arriving meanwhile are dropped
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg <= 1) begin
          cnt_next = '0;
          case (st_reg)
            sfl_pkg::SFL_EDPD:  st_next = sfl_pkg::SFL_DPD;
            sfl_pkg::SFL_EUDPD: st_next = sfl_pkg::SFL_UDPD;
            default:            st_next = sfl_pkg::SFL_IDLE;
          endcase
        end
      end
      sfl_pkg::SFL_DPD: begin
        if (cs_rise && byte_cnt_reg != 2'h0 && opcode_reg == sfl_pkg::OP_RESUME) begin
          st_next  = sfl_pkg::SFL_WAKE;
          cnt_next = load_cnt(sfl_pkg::RDPD_CYC);
        end
      end
      sfl_pkg::SFL_UDPD: begin
        if (!cs_n_s) begin
          st_next  = sfl_pkg::SFL_WAKE;
          cnt_next = load_cnt(sfl_pkg::XUDPD_CYC);
        end
      end
      default: begin
        st_next  = sfl_pkg::SFL_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  // State, counter and status flags
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg       <= sfl_pkg::SFL_IDLE;
      cnt_reg      <= '0;
      busy_out     <= 1'b0;
      pwr_down_out <= 1'b0;
      ultra_pd_out <= 1'b0;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      busy_out     <= (st_next != sfl_pkg::SFL_IDLE);
      pwr_down_out <= (st_next == sfl_pkg::SFL_DPD);
      ultra_pd_out <= (st_next == sfl_pkg::SFL_UDPD);
    end
  end

  // Protection tracks the synchronised pin within a few cycles
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      protect_out <= 1'b0;
    end else begin
      protect_out <= !wp_n_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_dpd_cmd;
    st_reg == sfl_pkg::SFL_IDLE && cs_rise && byte_cnt_reg != 2'h0 && opcode_reg == sfl_pkg::OP_DPD;
  endsequence

  sequence s_resume_cmd;
    st_reg == sfl_pkg::SFL_DPD && cs_rise && byte_cnt_reg != 2'h0
      && opcode_reg == sfl_pkg::OP_RESUME;
  endsequence

  chk_rx_sample_rise: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    spi_on && sck_rise |=> sh_in_reg[0] == $past(si_s, 2))
    else $error("receive bit not taken from serial input on clock rise");

  chk_tx_launch_fall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $changed(so_out) && $past(spi_on) |-> $past(sck_fall))
    else $error("serial output changed away from a clock fall");

  chk_cs_abort_frame: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cs_n_s ##1 cs_n_s |-> bit_cnt_reg == 3'h0 && byte_cnt_reg == 2'h0 && !so_oe_out)
    else $error("partial command survived select high");

  chk_dpd_entry_time: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_dpd_cmd |-> ##[1:EDPD_N] pwr_down_out)
    else $error("deep power-down not reached in time");

  chk_resume_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_resume_cmd |=> st_reg == sfl_pkg::SFL_WAKE
      && cnt_reg == sfl_pkg::CNT_W'(sfl_pkg::RDPD_CYC - sfl_pkg::PIN_LAT))
    else $error("resume did not start the recovery count");

  chk_udpd_entry_time: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(st_reg == sfl_pkg::SFL_EUDPD) |-> ##[1:EUDPD_N] ultra_pd_out)
    else $error("ultra-deep power-down not reached in time");

  chk_udpd_wake_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_reg == sfl_pkg::SFL_UDPD && !cs_n_s |=> st_reg == sfl_pkg::SFL_WAKE
      && cnt_reg == sfl_pkg::CNT_W'(sfl_pkg::XUDPD_CYC - sfl_pkg::PIN_LAT) ##1 busy_out)
    else $error("select pulse did not wake ultra-deep power-down");

  chk_xfer_busy_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_reg == sfl_pkg::SFL_IDLE && cs_rise && byte_cnt_reg != 2'h0
      && (opcode_reg == sfl_pkg::OP_XFER || opcode_reg == sfl_pkg::OP_COMP)
      |=> cnt_reg == sfl_pkg::CNT_W'(sfl_pkg::XFR_CYC - sfl_pkg::PIN_LAT) ##1 busy_out)
    else $error("transfer did not load its busy time");

  chk_busy_countdown: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_reg == sfl_pkg::SFL_BUSY && cnt_reg > 1 |=> st_reg == sfl_pkg::SFL_BUSY
      && cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("busy count stalled or left early");

  chk_protect_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(wp_n_s) ##1 !wp_n_s |-> ##[0:WP_N] protect_out)
    else $error("protection not enabled in time");
endmodule : sfl_link

// [verilog/sfl_pkg.sv]
package sfl_pkg;

  // ----------------------------------------------------------------------------
  // Clock rate and documented times
  // ----------------------------------------------------------------------------
  localparam int CLK_MHZ      = 20;
  localparam int T_EDPD_US    = 3;
  localparam int T_EUDPD_US   = 3;
  localparam int T_XUDPD_US   = 100;
  localparam int T_RDPD_US    = 35;
  localparam int T_XFR_US     = 200;
  localparam int T_COMP_US    = 200;
  localparam int T_WP_US      = 1;
  localparam int T_EP_MS      = 55;
  localparam int T_P_MS       = 4;

  // Cycle counts, longest times rounded down
  localparam int EDPD_CYC     = T_EDPD_US * CLK_MHZ;
  localparam int EUDPD_CYC    = T_EUDPD_US * CLK_MHZ;
  localparam int XUDPD_CYC    = T_XUDPD_US * CLK_MHZ;
  localparam int RDPD_CYC     = T_RDPD_US * CLK_MHZ;
  localparam int XFR_CYC      = T_XFR_US * CLK_MHZ;
  localparam int COMP_CYC     = T_COMP_US * CLK_MHZ;
  localparam int WP_CYC       = T_WP_US * CLK_MHZ;
  localparam int EP_CYC       = T_EP_MS * 1000 * CLK_MHZ;
  localparam int P_CYC        = T_P_MS * 1000 * CLK_MHZ;
  localparam int CNT_W        = 21;
  localparam int PIN_LAT      = 4; // Pin edge to registered answer: two syncs, edge, output

  // ----------------------------------------------------------------------------
  // Command codes and data path
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OP_DPD    = 8'hb9;
  localparam logic [7:0] OP_RESUME = 8'hab;
  localparam logic [7:0] OP_UDPD   = 8'h79;
  localparam logic [7:0] OP_XFER   = 8'h53;
  localparam logic [7:0] OP_COMP   = 8'h60;
  localparam logic [7:0] OP_EPROG  = 8'h82;
  localparam logic [7:0] OP_PROG   = 8'h88;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam int         DATA_W    = 8;
  localparam int         FIFO_D    = 8;

  // Link state, one-hot
  typedef enum logic [6:0] {
    SFL_IDLE  = 7'h01,
    SFL_BUSY  = 7'h02,
    SFL_EDPD  = 7'h04,
    SFL_DPD   = 7'h08,
    SFL_EUDPD = 7'h10,
    SFL_UDPD  = 7'h20,
    SFL_WAKE  = 7'h40
  } sfl_state_e;

endpackage : sfl_pkg
